// ---- eiac_pkg.sv ----
package eiac_pkg;

   // ----------------------------------------------------------------
   // Register word indices (byte address is index times four)
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_RX_CFG  = 10'h102;
   localparam logic [9:0] IDX_RX_CTL  = 10'h104;
   localparam logic [9:0] IDX_TX_CFG  = 10'h106;
   localparam logic [9:0] IDX_TX_CMD  = 10'h108;
   localparam logic [9:0] IDX_BUF_CFG = 10'h10A;
   localparam logic [9:0] IDX_LINE    = 10'h112;
   localparam logic [9:0] IDX_SELF    = 10'h114;
   localparam logic [9:0] IDX_BUS     = 10'h116;
   localparam logic [9:0] IDX_TEST    = 10'h118;
   localparam logic [9:0] IDX_RX_EV   = 10'h124;
   localparam logic [9:0] IDX_TX_EV   = 10'h128;
   localparam logic [9:0] IDX_BUF_EV  = 10'h12C;
   localparam logic [9:0] IDX_MISS    = 10'h130;
   localparam logic [9:0] IDX_COLL    = 10'h132;
   localparam logic [9:0] IDX_IRQ_ST  = 10'h140;
   localparam logic [9:0] IDX_IRQ_MSK = 10'h141;

   // ----------------------------------------------------------------
   // Register identity codes in bits 5:0
   // ----------------------------------------------------------------
   localparam logic [5:0] CODE_RX_CFG  = 6'h03;
   localparam logic [5:0] CODE_RX_CTL  = 6'h05;
   localparam logic [5:0] CODE_TX_CFG  = 6'h07;
   localparam logic [5:0] CODE_TX_CMD  = 6'h09;
   localparam logic [5:0] CODE_BUF_CFG = 6'h0B;
   localparam logic [5:0] CODE_LINE    = 6'h13;
   localparam logic [5:0] CODE_SELF    = 6'h15;
   localparam logic [5:0] CODE_BUS     = 6'h17;
   localparam logic [5:0] CODE_TEST    = 6'h19;
   localparam logic [5:0] CODE_RX_EV   = 6'h04;
   localparam logic [5:0] CODE_TX_EV   = 6'h08;
   localparam logic [5:0] CODE_BUF_EV  = 6'h0C;
   localparam logic [5:0] CODE_MISS    = 6'h10;
   localparam logic [5:0] CODE_COLL    = 6'h12;

   // ----------------------------------------------------------------
   // Flag positions within the 10-bit field (word bit minus 6)
   // ----------------------------------------------------------------
   localparam int B_ACT_ONCE = 0;   // Word bit 6 in every act-once register
   localparam int B_RX_EXTRA = 8;
   localparam int B_RX_RUNT  = 7;
   localparam int B_RX_CRC   = 6;
   localparam int B_RX_GOOD  = 2;
   localparam int B_A_BCAST  = 5;
   localparam int B_A_OWN    = 4;
   localparam int B_A_GROUP  = 3;
   localparam int B_A_ALL    = 1;
   localparam int B_A_HASH   = 0;
   localparam int B_TX_ANY   = 5;
   localparam int B_BUF_MOVF = 7;
   localparam int B_BUF_COVF = 6;
   localparam int B_BUS_IRQ  = 9;
   localparam int CNT_TOP    = 9;   // Counter bit that flags passing 1FFh

   // Enable masks of event bits that pair one-to-one with config bits
   localparam logic [9:0] RX_IE_MASK  = 10'h1C4;
   localparam logic [9:0] TX_IE_MASK  = 10'h21F;
   localparam logic [9:0] BUF_IE_MASK = 10'h23E;
   localparam logic [9:0] CTRL_RESET  = 10'h000;

endpackage : eiac_pkg

// ---- event_flags.sv ----
`timescale 1ns/1ps
module event_flags #(
   parameter int WIDTH = 10
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Control
   input  wire logic [WIDTH-1:0] set,
   input  wire logic             clr,
   // State
   output logic      [WIDTH-1:0] flags
);

   if (WIDTH < 1) begin : g_chk
      $error("event_flags: WIDTH must be at least 1");
   end

   // Sticky flags; an event in the clearing read cycle survives
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flags <= '0;
      end else begin
         flags <= (flags & ~{WIDTH{clr}}) | set;
      end
   end

endmodule : event_flags

// ---- read_clear_counter.sv ----
`timescale 1ns/1ps
module read_clear_counter #(
   parameter int WIDTH = 10
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Control
   input  wire logic             inc,
   input  wire logic             clr,
   // Count
   output logic      [WIDTH-1:0] count
);

   if (WIDTH < 2) begin : g_chk
      $error("read_clear_counter: WIDTH must be at least 2");
   end

   // Wraps past all ones; a count during the clearing read is kept
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         count <= '0;
      end else if (clr) begin
         count <= {{(WIDTH-1){1'b0}}, inc};
      end else if (inc) begin
         count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

endmodule : read_clear_counter

// ---- event_interrupt_accept_control.sv ----
// The APB register port was left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Interrupt enables live in receive, transmit and buffer configuration registers.
// - Set enable plus its event raises an interrupt request.
// - Events reported in three event registers and two counters.
// - Event bits set on their event whatever the enable holds.
// - Reading an event register clears all of it.
// - Receive and transmit enables each pair with one event source.
// - Buffer enables cover counter overflow past 1FFh and buffer events.
// - Nine accept bits in receive control select frame classes.
// - A frame counts as accepted only when it is stored.
// - Four accept bits and matching enables act independently.
// - Enabled but unaccepted receive event interrupts, discards, length zero.
// - Five accept bits drive destination address filtering.
// - Low six bits hold register code; bit 0 marks control registers.
// - Act-once bits act once per write of one and read zero.
module event_interrupt_accept_control (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Receive frame status from the MAC
   input  wire logic        rx_frame_done,
   input  wire logic        rx_extra,
   input  wire logic        rx_runt,
   input  wire logic        rx_crc_bad,
   input  wire logic        rx_good,
   input  wire logic        rx_bcast,
   input  wire logic        rx_own,
   input  wire logic        rx_hashed,
   input  wire logic        rx_dribble,
   input  wire logic        rx_own_hashed,
   input  wire logic [15:0] rx_length,
   // Transmit status from the MAC
   input  wire logic        tx_done,
   input  wire logic        tx_16coll,
   input  wire logic [3:0]  tx_coll_num,
   input  wire logic        tx_jabber,
   input  wire logic        tx_late,
   input  wire logic        tx_good,
   input  wire logic        tx_heartbeat_err,
   input  wire logic        tx_carrier_loss,
   input  wire logic        tx_collision,
   input  wire logic [9:0]  transmit_command_readback,
   // Buffer events
   input  wire logic        rx_dest,
   input  wire logic        rx_first_block,
   input  wire logic        rx_missed,
   input  wire logic        tx_underflow,
   input  wire logic        tx_space,
   input  wire logic        dma_frame_done_flag,
   // Frame store decision
   output logic             frame_valid,
   output logic             frame_store,
   output logic      [15:0] frame_length,
   // Act-once strobes and interrupt
   output logic             skip_frame,
   output logic             chip_reset_pulse,
   output logic             receive_dma_restart,
   output logic             irq
);

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic [9:0] receive_configuration, receive_control_accept, transmit_configuration;
   logic [9:0] buffer_configuration, line_control, self_control, bus_control;
   logic [9:0] test_control;
   logic [9:0] receive_event_register, transmit_flags, buffer_event_register;
   logic [9:0] missed_frame_counter, collision_counter;
   logic [3:0] tx_coll_field;
   logic       any_coll_seen;
   logic [2:0] irq_status, irq_mask;
   logic [9:0] widx;
   logic       done, wr, rd;
   logic [9:0] wf;
   logic [9:0] transmit_event_register;
   logic [31:0] rdata;
   logic       mapped;

   assign widx = paddr[11:2];
   assign done = psel & penable & pready;
   assign wr   = done & pwrite;
   assign rd   = done & ~pwrite;
   assign wf   = pwdata[15:6];
   assign transmit_event_register = {transmit_flags[9], tx_coll_field, transmit_flags[4:0]};
   // Read mux; act-once bits always read as zero
   always_comb begin
      rdata  = 32'h0000_0000;
      mapped = 1'b1;
      case (widx)
         eiac_pkg::IDX_RX_CFG:  rdata[15:0] = {receive_configuration[9:1], 1'b0,
                                              eiac_pkg::CODE_RX_CFG};
         eiac_pkg::IDX_RX_CTL:  rdata[15:0] = {receive_control_accept, eiac_pkg::CODE_RX_CTL};
         eiac_pkg::IDX_TX_CFG:  rdata[15:0] = {transmit_configuration, eiac_pkg::CODE_TX_CFG};
         eiac_pkg::IDX_TX_CMD:  rdata[15:0] = {transmit_command_readback,
                                              eiac_pkg::CODE_TX_CMD};
         eiac_pkg::IDX_BUF_CFG: rdata[15:0] = {buffer_configuration[9:1], 1'b0,
                                              eiac_pkg::CODE_BUF_CFG};
         eiac_pkg::IDX_LINE:    rdata[15:0] = {line_control, eiac_pkg::CODE_LINE};
         eiac_pkg::IDX_SELF:    rdata[15:0] = {self_control[9:1], 1'b0, eiac_pkg::CODE_SELF};
         eiac_pkg::IDX_BUS:     rdata[15:0] = {bus_control[9:1], 1'b0, eiac_pkg::CODE_BUS};
         eiac_pkg::IDX_TEST:    rdata[15:0] = {test_control, eiac_pkg::CODE_TEST};
         eiac_pkg::IDX_RX_EV:   rdata[15:0] = {receive_event_register,
                                              eiac_pkg::CODE_RX_EV};
         eiac_pkg::IDX_TX_EV:   rdata[15:0] = {transmit_event_register, eiac_pkg::CODE_TX_EV};
         eiac_pkg::IDX_BUF_EV:  rdata[15:0] = {buffer_event_register, eiac_pkg::CODE_BUF_EV};
         eiac_pkg::IDX_MISS:    rdata[15:0] = {missed_frame_counter, eiac_pkg::CODE_MISS};
         eiac_pkg::IDX_COLL:    rdata[15:0] = {collision_counter, eiac_pkg::CODE_COLL};
         eiac_pkg::IDX_IRQ_ST:  rdata[2:0]  = irq_status;
         eiac_pkg::IDX_IRQ_MSK: rdata[2:0]  = irq_mask;
         default:               mapped      = 1'b0;
      endcase
   end

   // Two-cycle access: wait state, then registered answer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & penable & ~pready;
         prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata : 32'h0000_0000;
         pslverr <= psel & penable & ~pready & ~mapped;
      end
   end

   // ----------------------------------------------------------------
   // Configuration and control registers
   // ----------------------------------------------------------------
   // Plain storage; act-once positions never hold a one
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         receive_configuration  <= eiac_pkg::CTRL_RESET;
         receive_control_accept <= eiac_pkg::CTRL_RESET;
         transmit_configuration <= eiac_pkg::CTRL_RESET;
         buffer_configuration   <= eiac_pkg::CTRL_RESET;
         line_control           <= eiac_pkg::CTRL_RESET;
         self_control           <= eiac_pkg::CTRL_RESET;
         bus_control            <= eiac_pkg::CTRL_RESET;
         test_control           <= eiac_pkg::CTRL_RESET;
         irq_mask               <= 3'h0;
      end else if (wr) begin
         case (widx)
            eiac_pkg::IDX_RX_CFG:  receive_configuration  <= {wf[9:1], 1'b0};
            eiac_pkg::IDX_RX_CTL:  receive_control_accept <= wf;
            eiac_pkg::IDX_TX_CFG:  transmit_configuration <= wf;
            eiac_pkg::IDX_BUF_CFG: buffer_configuration   <= {wf[9:1], 1'b0};
            eiac_pkg::IDX_LINE:    line_control           <= wf;
            eiac_pkg::IDX_SELF:    self_control           <= {wf[9:1], 1'b0};
            eiac_pkg::IDX_BUS:     bus_control            <= {wf[9:1], 1'b0};
            eiac_pkg::IDX_TEST:    test_control           <= wf;
            eiac_pkg::IDX_IRQ_MSK: irq_mask               <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // Act-once strobes: one cycle per write of a one
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         skip_frame          <= 1'b0;
         chip_reset_pulse    <= 1'b0;
         receive_dma_restart <= 1'b0;
      end else begin
         skip_frame          <= wr & (widx == eiac_pkg::IDX_RX_CFG) & wf[0];
         chip_reset_pulse    <= wr & (widx == eiac_pkg::IDX_SELF) & wf[0];
         receive_dma_restart <= wr & (widx == eiac_pkg::IDX_BUS) & wf[0];
      end
   end

   // ----------------------------------------------------------------
   // Event registers and counters
   // ----------------------------------------------------------------
   logic rd_rx, rd_tx, rd_buf, rd_miss, rd_coll, sw_int;
   logic [9:0] rx_set, tx_set, buf_set;
   assign rd_rx   = rd & (widx == eiac_pkg::IDX_RX_EV);
   assign rd_tx   = rd & (widx == eiac_pkg::IDX_TX_EV);
   assign rd_buf  = rd & (widx == eiac_pkg::IDX_BUF_EV);
   assign rd_miss = rd & (widx == eiac_pkg::IDX_MISS);
   assign rd_coll = rd & (widx == eiac_pkg::IDX_COLL);
   assign sw_int  = wr & (widx == eiac_pkg::IDX_BUF_CFG) & wf[0];
   // Event sets ignore enables entirely
   assign rx_set  = {10{rx_frame_done}} & {1'b0, rx_extra, rx_runt, rx_crc_bad, rx_bcast,
                    rx_own, rx_hashed, rx_good, rx_dribble, rx_own_hashed};
   assign tx_set  = {10{tx_done}} & {tx_16coll, 4'h0, tx_jabber, tx_late, tx_good,
                    tx_heartbeat_err, tx_carrier_loss};
   assign buf_set = {rx_dest, 3'h0, rx_first_block, rx_missed, tx_underflow, tx_space,
                     dma_frame_done_flag, sw_int};
   event_flags #(.WIDTH(10)) u_rx_ev (
      .clk   (clk),
      .nrst  (nrst),
      .set   (rx_set),
      .clr   (rd_rx),
      .flags (receive_event_register)
   );
   event_flags #(.WIDTH(10)) u_tx_ev (
      .clk   (clk),
      .nrst  (nrst),
      .set   (tx_set),
      .clr   (rd_tx),
      .flags (transmit_flags)
   );
   event_flags #(.WIDTH(10)) u_buf_ev (
      .clk   (clk),
      .nrst  (nrst),
      .set   (buf_set),
      .clr   (rd_buf),
      .flags (buffer_event_register)
   );
   read_clear_counter #(.WIDTH(10)) u_miss (
      .clk   (clk),
      .nrst  (nrst),
      .inc   (rx_missed),
      .clr   (rd_miss),
      .count (missed_frame_counter)
   );
   read_clear_counter #(.WIDTH(10)) u_coll (
      .clk   (clk),
      .nrst  (nrst),
      .inc   (tx_collision),
      .clr   (rd_coll),
      .count (collision_counter)
   );

   // Collision count field and any-collision pending, cleared with the event read
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_coll_field <= 4'h0;
         any_coll_seen <= 1'b0;
      end else begin
         if (tx_done) begin
            tx_coll_field <= tx_coll_num;
         end else if (rd_tx) begin
            tx_coll_field <= 4'h0;
         end
         any_coll_seen <= (any_coll_seen & ~rd_tx) | tx_collision;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt request
   // ----------------------------------------------------------------
   logic rx_pend, tx_pend, buf_pend, next_irq;
   assign rx_pend  = |(receive_event_register & receive_configuration
                      & eiac_pkg::RX_IE_MASK);
   assign tx_pend  = |(transmit_flags & transmit_configuration & eiac_pkg::TX_IE_MASK)
                   | (any_coll_seen & transmit_configuration[eiac_pkg::B_TX_ANY]);
   assign buf_pend = |(buffer_event_register & buffer_configuration & eiac_pkg::BUF_IE_MASK)
                   | buffer_event_register[eiac_pkg::B_ACT_ONCE]
                   | (missed_frame_counter[eiac_pkg::CNT_TOP]
                      & buffer_configuration[eiac_pkg::B_BUF_MOVF])
                   | (collision_counter[eiac_pkg::CNT_TOP]
                      & buffer_configuration[eiac_pkg::B_BUF_COVF]);
   // Sticky group status, write one to clear; a new event wins over the clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_status <= 3'h0;
      end else begin
         irq_status <= (irq_status & ~((wr && widx == eiac_pkg::IDX_IRQ_ST) ? pwdata[2:0]
                       : 3'h0)) | {buf_pend, tx_pend, rx_pend};
      end
   end
   // Pending terms withdraw when the host reads the source or clears its enable
   assign next_irq = bus_control[eiac_pkg::B_BUS_IRQ]
                   & (rx_pend | tx_pend | buf_pend | |(irq_status & irq_mask));

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   // ----------------------------------------------------------------
   // Receive accept decision
   // ----------------------------------------------------------------
   logic class_ok, addr_ok;
   // Error classes each own an accept bit, decided apart from their enables
   assign class_ok = rx_extra   ? receive_control_accept[eiac_pkg::B_RX_EXTRA]
                   : rx_runt    ? receive_control_accept[eiac_pkg::B_RX_RUNT]
                   : rx_crc_bad ? receive_control_accept[eiac_pkg::B_RX_CRC]
                   : (rx_good & receive_control_accept[eiac_pkg::B_RX_GOOD]);
   assign addr_ok  = receive_control_accept[eiac_pkg::B_A_ALL]
                   | (rx_bcast & receive_control_accept[eiac_pkg::B_A_BCAST])
                   | (rx_own & receive_control_accept[eiac_pkg::B_A_OWN])
                   | (rx_hashed & receive_control_accept[eiac_pkg::B_A_GROUP])
                   | (rx_own_hashed & receive_control_accept[eiac_pkg::B_A_HASH]);
   // Rejected frames are discarded and report zero length
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         frame_valid  <= 1'b0;
         frame_store  <= 1'b0;
         frame_length <= 16'h0000;
      end else begin
         frame_valid  <= rx_frame_done;
         frame_store  <= rx_frame_done & class_ok & addr_ok;
         frame_length <= (rx_frame_done & class_ok & addr_ok) ? rx_length : 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_irq_gated;
      @(posedge clk) disable iff (!nrst)
      irq |-> $past(bus_control[eiac_pkg::B_BUS_IRQ]);
   endproperty
   a_irq_gated: assert property (p_irq_gated) else $error("irq without global enable");
   property p_rx_irq;
      @(posedge clk) disable iff (!nrst)
      (receive_event_register[eiac_pkg::B_RX_GOOD] && receive_configuration[eiac_pkg::B_RX_GOOD]
       && bus_control[eiac_pkg::B_BUS_IRQ]) |=> irq;
   endproperty
   a_rx_irq: assert property (p_rx_irq) else $error("enabled event gave no irq");
   property p_event_set;
      @(posedge clk) disable iff (!nrst)
      (rx_frame_done && rx_crc_bad) |=> receive_event_register[eiac_pkg::B_RX_CRC];
   endproperty
   a_event_set: assert property (p_event_set) else $error("event bit not set");
   property p_read_clear;
      @(posedge clk) disable iff (!nrst)
      (rd_tx && !tx_done) |=> (transmit_event_register == 10'h000);
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("event not cleared by read");
   property p_act_once_zero;
      @(posedge clk) disable iff (!nrst)
      (rd && widx == eiac_pkg::IDX_BUF_CFG) |-> (prdata[6] == 1'b0 && prdata[0] == 1'b1);
   endproperty
   a_act_once_zero: assert property (p_act_once_zero) else $error("act-once read one");
   property p_skip_once;
      @(posedge clk) disable iff (!nrst)
      skip_frame |=> !skip_frame;
   endproperty
   a_skip_once: assert property (p_skip_once) else $error("skip strobe longer than one");
   property p_reject_len;
      @(posedge clk) disable iff (!nrst)
      (frame_valid && !frame_store) |-> (frame_length == 16'h0000);
   endproperty
   a_reject_len: assert property (p_reject_len) else $error("rejected frame has length");
   property p_code;
      @(posedge clk) disable iff (!nrst)
      (rd && widx == eiac_pkg::IDX_MISS) |-> (prdata[5:0] == eiac_pkg::CODE_MISS);
   endproperty
   a_code: assert property (p_code) else $error("wrong register code");
   property p_ovf_irq;
      @(posedge clk) disable iff (!nrst)
      (missed_frame_counter[eiac_pkg::CNT_TOP] && buffer_configuration[eiac_pkg::B_BUF_MOVF]
       && bus_control[eiac_pkg::B_BUS_IRQ]) |=> irq;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("overflow gave no irq");

endmodule : event_interrupt_accept_control

// ---- mac_event_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Receive frame and buffer event source
// ----------------------------------------------------------------
module mac_event_model (
   // Clock
   input  wire logic        clk,
   // Frame status
   output logic             rx_done,
   output logic [8:0]       rx_f,
   output logic [15:0]      rx_len,
   // Buffer event pulses
   output logic [5:0]       buf_p
);
   // Quiet at time zero
   initial begin
      rx_done = 1'b0;
      rx_f = 9'h000;
      rx_len = 16'h0000;
      buf_p = 6'h00;
   end
   // Qualifiers scramble once the pulse is gone, so nothing leans on stale levels
   task automatic frame(input logic [8:0] f, input logic [15:0] n);
      @(posedge clk);
      rx_done <= 1'b1;
      rx_f <= f;
      rx_len <= n;
      @(posedge clk);
      rx_done <= 1'b0;
      rx_f <= ~f;
      rx_len <= ~n;
   endtask : frame
   // One-cycle buffer event
   task automatic pulse(input int i);
      @(posedge clk);
      buf_p[i] <= 1'b1;
      @(posedge clk);
      buf_p[i] <= 1'b0;
   endtask : pulse
endmodule : mac_event_model

// ---- test_event_interrupt_accept_control.sv ----
`timescale 1ns/1ps
module test_event_interrupt_accept_control;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, coll = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   logic pready, pslverr, fv, fs, skip, crst, dmar, irq, done, er;
   logic [31:0] prdata;
   logic [15:0] flen, len;
   logic [8:0] f;
   logic [5:0] bp;
   logic [12:0] tx_v = 13'h0000;
   int err_count = 0, n_tests = 0, cyc = 0, seen;
   always #20 clk = ~clk;
   // ----------------------------------------------------------------
   // Design and far side
   // ----------------------------------------------------------------
   event_interrupt_accept_control i_event_interrupt_accept_control (.clk(clk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_frame_done(done),
      .rx_extra(f[8]), .rx_runt(f[7]), .rx_crc_bad(f[6]), .rx_good(f[5]), .rx_bcast(f[4]),
      .rx_own(f[3]), .rx_hashed(f[2]), .rx_dribble(f[1]), .rx_own_hashed(f[0]),
      .rx_length(len), .tx_done(tx_v[12]), .tx_16coll(tx_v[11]), .tx_coll_num(tx_v[10:7]),
      .tx_jabber(tx_v[6]), .tx_late(tx_v[5]), .tx_good(tx_v[4]), .tx_heartbeat_err(tx_v[3]),
      .tx_carrier_loss(tx_v[2]), .tx_collision(coll), .transmit_command_readback(10'h000),
      .rx_dest(bp[0]), .rx_first_block(bp[1]), .rx_missed(bp[2]), .tx_underflow(bp[3]),
      .tx_space(bp[4]), .dma_frame_done_flag(bp[5]), .frame_valid(fv), .frame_store(fs),
      .frame_length(flen), .skip_frame(skip), .chip_reset_pulse(crst),
      .receive_dma_restart(dmar), .irq(irq));
   mac_event_model i_mac_event_model (.clk(clk), .rx_done(done), .rx_f(f), .rx_len(len),
      .buf_p(bp));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [9:0] ix, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ix, 2'b00, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   // Hang guard, far above the 1,150 or so cycles the run needs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         give_verdict();
      end
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      apb(0, eiac_pkg::IDX_RX_CFG, 0);
      chk("rx_cfg", 32'h3, rd);
      apb(0, eiac_pkg::IDX_RX_EV, 0);
      chk("rx_ev", 32'h4, rd);
      apb(0, 10'h3FF, 0);
      chk("unmapped", 32'h1, {rd[30:0], er});
   endtask : t_reset
   // Event without enable: flag set, no irq, cleared by read
   task automatic t_silent;
      apb(1, eiac_pkg::IDX_BUS, 32'h8000);
      i_mac_event_model.frame(9'h020, 16'h0040);
      repeat (2) @(posedge clk);
      #1 chk("irq", 0, irq);
      apb(0, eiac_pkg::IDX_RX_EV, 0);
      chk("rx_ev", 32'h104, rd);
      apb(0, eiac_pkg::IDX_RX_EV, 0);
      chk("rx_ev", 32'h4, rd);
   endtask : t_silent
   // Enabled but not accepted, then accepted through promiscuous filter
   task automatic t_accept;
      apb(1, eiac_pkg::IDX_RX_CFG, 32'h100);
      i_mac_event_model.frame(9'h020, 16'h0040);
      #1 chk("store", 32'h0, {fv ^ 1'b1, fs, flen});
      repeat (2) @(posedge clk);
      #1 chk("irq", 1, irq);
      apb(0, eiac_pkg::IDX_RX_EV, 0);
      repeat (2) @(posedge clk);
      #1 chk("irq", 0, irq);
      apb(1, eiac_pkg::IDX_RX_CTL, 32'h180);
      i_mac_event_model.frame(9'h020, 16'h0040);
      #1 chk("store", 32'h10040, {fv ^ 1'b1, fs, flen});
      apb(0, eiac_pkg::IDX_RX_EV, 0);
   endtask : t_accept
   // Buffer events, both counters and the transmit event word
   task automatic t_buf;
      i_mac_event_model.pulse(0);
      apb(0, eiac_pkg::IDX_BUF_EV, 0);
      chk("buf_ev", 32'h800C, rd);
      @(posedge clk) coll <= 1'b1;
      @(posedge clk) coll <= 1'b0;
      apb(0, eiac_pkg::IDX_COLL, 0);
      chk("coll", 32'h52, rd);
      repeat (512) i_mac_event_model.pulse(2);
      apb(1, eiac_pkg::IDX_BUF_CFG, 32'h2000);
      repeat (2) @(posedge clk);
      #1 chk("irq", 1, irq);
      apb(0, eiac_pkg::IDX_MISS, 0);
      chk("miss", 32'h8010, rd);
      repeat (2) @(posedge clk);
      #1 chk("irq", 0, irq);
      @(posedge clk) tx_v <= 13'h1A90;
      @(posedge clk) tx_v <= 13'h0000;
      apb(0, eiac_pkg::IDX_TX_EV, 0);
      chk("tx_ev", 32'hA908, rd);
   endtask : t_buf
   // Act-once pulse exactly once, bit reads clear
   task automatic t_once;
      seen = 0;
      apb(1, eiac_pkg::IDX_SELF, 32'h40);
      repeat (3) @(posedge clk) seen += crst;
      apb(1, eiac_pkg::IDX_RX_CFG, 32'h40);
      repeat (3) @(posedge clk) seen += skip;
      apb(1, eiac_pkg::IDX_BUS, 32'h8040);
      repeat (3) @(posedge clk) seen += dmar;
      chk("pulses", 3, seen);
      apb(0, eiac_pkg::IDX_SELF, 0);
      chk("self", 32'h15, rd);
      apb(1, eiac_pkg::IDX_BUF_CFG, 32'h40);
      apb(0, eiac_pkg::IDX_BUF_CFG, 0);
      chk("buf_cfg", 32'hB, rd);
      apb(0, eiac_pkg::IDX_BUF_EV, 0);
      chk("swint", 32'h44C, rd);
   endtask : t_once
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_silent();
      t_accept();
      t_buf();
      t_once();
      give_verdict();
   end
endmodule : test_event_interrupt_accept_control
